// ==== logic/led_cfg_pkg.sv ====
/*
 * Shared constants and types of the dimming configuration register bank.
 * Assumes a 20 MHz system clock and the register layout listed here.
 */
package led_cfg_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int FIXED_RATE_HZ = 26_000;
    localparam logic [9:0] RATE_CYC = 10'(CLK_HZ / FIXED_RATE_HZ);
    localparam logic [9:0] RATE_LAST = RATE_CYC - 10'h001;

    localparam logic [6:0] TARGET_ADDR = 7'h31;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    localparam int NUM_SLOTS = 17;
    localparam int SLOT_DIM = 0;
    localparam int SLOT_CUR = 2;
    localparam int SLOT_BLO = 4;
    localparam int SLOT_BHI = 5;
    localparam int SLOT_OTP = 16;
    localparam int OTP_GO_BIT = 0;
    localparam logic [2:0] OTP_WORDS = 3'h4;

    localparam logic [NUM_SLOTS-1:0][7:0] SLOT_ADDR = {
        8'h60, 8'h51, 8'h50, 8'h0E, 8'h0D, 8'h0B, 8'h0A, 8'h09, 8'h08,
        8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
    localparam logic [NUM_SLOTS-1:0][7:0] SLOT_RST = {
        8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h04, 8'h1C, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h92, 8'h76, 8'h4C};
    localparam logic [NUM_SLOTS-1:0] SLOT_WRITABLE = 17'h13FFF;

    localparam logic [1:0] DUTY_ZERO = 2'h0;
    localparam logic [3:0][2:0] DUTY_SIXTEENTHS = {3'h4, 3'h2, 3'h1, 3'h0};
    localparam logic [15:0] BRIGHT_FULL = 16'h0400;

    typedef logic [4:0] slot_t;

    typedef struct packed {
        logic fixed_rate;
        logic [1:0] edge_rate;
        logic spread;
        logic [1:0] change_duty;
        logic bright_sel;
        logic mode;
    } dim_ctrl_t;

    typedef enum logic [1:0] {
        DIM_PWM = 2'b00,
        DIM_DC = 2'b01,
        DIM_MIXED = 2'b10
    } dim_mode_t;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_ACK = 3'b010,
        I_REG = 3'b011,
        I_WDATA = 3'b100,
        I_RDATA = 3'b101,
        I_RACK = 3'b110
    } i2c_state_t;

    typedef enum logic [1:0] {
        OTP_LOAD = 2'b00,
        OTP_IDLE = 2'b01,
        OTP_PROG = 2'b10
    } otp_state_t;

endpackage : led_cfg_pkg

// ==== logic/otp_store.sv ====
/*
 * One-time storage for the first four configuration bytes, with a
 * programmed flag per word and registered read data.
 * Assumes the caller clears the flags only at power-on.
 */
`timescale 1ns/100ps
module otp_store (
    // clock and power-on clear
    input wire logic clk,
    input wire logic fuse_clear,
    // program port
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [1:0] raddr,
    output logic [7:0] rdata,
    output logic rprog
);
    logic [7:0] mem [4];
    logic [3:0] burnt_reg;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

    // flags survive system reset; only power-on clears them
    always_ff @(posedge clk) begin
        if (fuse_clear) begin
            burnt_reg <= 4'h0;
            rprog <= 1'b0;
        end else begin
            if (we) begin
                burnt_reg[waddr] <= 1'b1;
            end
            rprog <= burnt_reg[raddr];
        end
    end
endmodule : otp_store

// ==== logic/led_dimming_config_regs.sv ====
/*
 * I2C target register bank of a six-channel backlight driver: holds the
 * dimming controls, decodes the dimming mode and drives the sink stage.
 * Assumes open-drain SDA resolved outside, a 20 MHz clock, sync reset.
 */
// Contract
// - control bit 0 picks PWM (0) or mixed/DC (1) dimming, resetting to PWM.
// - control bits 3:2 set the mixed change duty 0, 6.25, 12.5 or 25 percent, reset 11.
// - with control bit 1 at 0, control bit 7 makes mixed output follow the pin rate (0) or a fixed 26 kHz (1).
// - mode bit 1 with change duty 00 means DC dimming, with no bit of its own.
// - registers dimming_control to regulator_and_compensation can be burnt into one-time storage as lasting settings.
// - all three dimming modes are chosen only through register dimming_control.
// - the bank answers I2C target address 0110001 at up to 400 kb/s.
// - control bit 1 takes brightness from the pin (0) or registers brightness_low_first/brightness_high_first (1).
// - in PWM mode with control bit 1 at 0 the sinks switch in step with the dimming input.
// - mixed mode below the threshold holds a quarter amplitude and chops on-time.
`timescale 1ns/100ps
module led_dimming_config_regs import led_cfg_pkg::*; (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic FUSE_CLEAR,
    // i2c pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // dimming input pin
    input wire logic DIM_IN,
    // sink stage
    output dim_ctrl_t DIM_CTRL,
    output dim_mode_t DIM_MODE,
    output logic LED_SINK_ON,
    output logic [7:0] LED_SINK_CURRENT,
    output logic OTP_BUSY
);
    logic [7:0] regs_reg [NUM_SLOTS];
    logic [2:0] scl_m_reg, sda_m_reg, dim_m_reg, clr_m_reg;
    logic scl_s, sda_s, dim_s, scl_d, sda_d, dim_d, fuse_clr;
    logic scl_rise, scl_fall, start, stop;
    i2c_state_t state_reg, ack_next_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, ptr_reg, wr_data_reg, rd_byte;
    logic sda_oe_n_reg, wr_en_reg, ptr_hit;
    slot_t wr_slot_reg, ptr_slot, ld_idx;
    otp_state_t otp_state_reg;
    logic [2:0] ld_cnt_reg;
    logic ld_en, prog_done, otp_rprog;
    logic [7:0] otp_rdata;
    logic [15:0] period_cnt_reg, high_cnt_reg, period_lat_reg, high_lat_reg, num, den;
    logic [9:0] rate_cnt_reg;
    dim_ctrl_t ctrl;
    dim_mode_t mode_now;
    logic src_reg, duty_below, fixed_on, chopped, pwm_on;
    logic [7:0] cur_byte;

    // pins cross in two stages; the third stage only feeds edge detection
    always_ff @(posedge SYS_CLK) begin
        scl_m_reg <= {scl_m_reg[1:0], SCL_IN};
        sda_m_reg <= {sda_m_reg[1:0], SDA_IN};
        dim_m_reg <= {dim_m_reg[1:0], DIM_IN};
        clr_m_reg <= {clr_m_reg[1:0], FUSE_CLEAR};
    end
    assign scl_s = scl_m_reg[1];
    assign sda_s = sda_m_reg[1];
    assign dim_s = dim_m_reg[1];
    assign fuse_clr = clr_m_reg[1];
    assign scl_d = scl_m_reg[2];
    assign sda_d = sda_m_reg[2];
    assign dim_d = dim_m_reg[2];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start = scl_s && scl_d && sda_d && !sda_s;
    assign stop = scl_s && scl_d && !sda_d && sda_s;

    function automatic logic [5:0] slot_of(input logic [7:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (SLOT_ADDR[i] == a) begin
                r = {1'b1, slot_t'(i)};
            end
        end
        return r;
    endfunction : slot_of

    assign {ptr_hit, ptr_slot} = slot_of(ptr_reg);
    assign rd_byte = ptr_hit ? regs_reg[ptr_slot] : 8'h00;

    // register slots: burnt load beats host write, host write beats self-clear
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : slot_g
        always_ff @(posedge SYS_CLK) begin
            if (RESET) begin
                regs_reg[g] <= SLOT_RST[g];
            end else if (ld_en && ld_idx == slot_t'(g)) begin
                regs_reg[g] <= otp_rdata;
            end else if (wr_en_reg && wr_slot_reg == slot_t'(g) && SLOT_WRITABLE[g]) begin
                regs_reg[g] <= wr_data_reg;
            end else if (g == SLOT_OTP && prog_done) begin
                regs_reg[g][OTP_GO_BIT] <= 1'b0;
            end
        end
    end

    // i2c target
    always_ff @(posedge SYS_CLK) begin
        wr_en_reg <= 1'b0;
        if (RESET) begin
            state_reg <= I_IDLE;
            ack_next_reg <= I_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sda_oe_n_reg <= 1'b1;
            wr_slot_reg <= 5'h00;
            wr_data_reg <= 8'h00;
        end else if (start) begin
            state_reg <= I_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
        end else if (stop) begin
            state_reg <= I_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                I_ADDR, I_REG, I_WDATA: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
                        bit_cnt_reg <= 4'h0;
                        sda_oe_n_reg <= 1'b0;
                        state_reg <= I_ACK;
                        case (state_reg)
                            I_ADDR: begin
                                ack_next_reg <= shift_reg[0] ? I_RDATA : I_REG;
                                if (shift_reg[7:1] != TARGET_ADDR) begin
                                    sda_oe_n_reg <= 1'b1;
                                    state_reg <= I_IDLE;
                                end
                            end
                            I_REG: begin
                                ptr_reg <= shift_reg;
                                ack_next_reg <= I_WDATA;
                            end
                            default: begin
                                wr_en_reg <= ptr_hit;
                                wr_slot_reg <= ptr_slot;
                                wr_data_reg <= shift_reg;
                                ptr_reg <= ptr_reg + 8'h01;
                                ack_next_reg <= I_WDATA;
                            end
                        endcase
                    end
                end
                I_ACK: begin
                    if (scl_fall) begin
                        state_reg <= ack_next_reg;
                        sda_oe_n_reg <= 1'b1;
                        if (ack_next_reg == I_RDATA) begin
                            shift_reg <= rd_byte;
                            sda_oe_n_reg <= rd_byte[7];
                        end
                    end
                end
                I_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == BYTE_BITS - 4'h1) begin
                            bit_cnt_reg <= 4'h0;
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= I_RACK;
                            ptr_reg <= ptr_reg + 8'h01;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_n_reg <= shift_reg[6];
                        end
                    end
                end
                I_RACK: begin
                    if (scl_rise) begin
                        state_reg <= sda_s ? I_IDLE : I_ACK;
                    end
                end
                default: begin
                    state_reg <= I_IDLE;
                end
            endcase
        end
    end
    assign SDA_OE_N = sda_oe_n_reg;

    always_ff @(posedge SYS_CLK) begin
        SDA_OUT <= 1'b0;
    end

    // one-time storage: load after reset, burn on request
    assign prog_done = otp_state_reg == OTP_PROG && ld_cnt_reg == OTP_WORDS - 3'h1;
    assign ld_en = otp_state_reg == OTP_LOAD && ld_cnt_reg != 3'h0 && otp_rprog;
    assign ld_idx = slot_t'(ld_cnt_reg - 3'h1);

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            otp_state_reg <= OTP_LOAD;
            ld_cnt_reg <= 3'h0;
            OTP_BUSY <= 1'b1;
        end else begin
            OTP_BUSY <= otp_state_reg != OTP_IDLE;
            case (otp_state_reg)
                OTP_LOAD: begin
                    ld_cnt_reg <= ld_cnt_reg + 3'h1;
                    if (ld_cnt_reg == OTP_WORDS) begin
                        otp_state_reg <= OTP_IDLE;
                        ld_cnt_reg <= 3'h0;
                    end
                end
                OTP_IDLE: begin
                    if (regs_reg[SLOT_OTP][OTP_GO_BIT]) begin
                        otp_state_reg <= OTP_PROG;
                    end
                end
                OTP_PROG: begin
                    ld_cnt_reg <= ld_cnt_reg + 3'h1;
                    if (prog_done) begin
                        otp_state_reg <= OTP_IDLE;
                        ld_cnt_reg <= 3'h0;
                    end
                end
                default: begin
                    otp_state_reg <= OTP_IDLE;
                end
            endcase
        end
    end

    otp_store u_otp (
        .clk(SYS_CLK),
        .fuse_clear(fuse_clr),
        .we(otp_state_reg == OTP_PROG),
        .waddr(ld_cnt_reg[1:0]),
        .wdata(regs_reg[ld_cnt_reg[1:0]]),
        .raddr(ld_cnt_reg[1:0]),
        .rdata(otp_rdata),
        .rprog(otp_rprog)
    );

    // duty measurement of the dimming pin, saturating on a stuck pin
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            period_cnt_reg <= 16'h0000;
            high_cnt_reg <= 16'h0000;
            period_lat_reg <= 16'h0000;
            high_lat_reg <= 16'h0000;
        end else if (dim_s && !dim_d) begin
            period_lat_reg <= period_cnt_reg;
            high_lat_reg <= high_cnt_reg;
            period_cnt_reg <= 16'h0001;
            high_cnt_reg <= 16'h0001;
        end else begin
            if (period_cnt_reg != 16'hFFFF) begin
                period_cnt_reg <= period_cnt_reg + 16'h0001;
            end
            if (dim_s && high_cnt_reg != 16'hFFFF) begin
                high_cnt_reg <= high_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rate_cnt_reg <= 10'h000;
        end else begin
            if (rate_cnt_reg == RATE_LAST) begin
                rate_cnt_reg <= 10'h000;
            end else begin
                rate_cnt_reg <= rate_cnt_reg + 10'h001;
            end
        end
    end

    assign ctrl = dim_ctrl_t'(regs_reg[SLOT_DIM]);
    assign cur_byte = regs_reg[SLOT_CUR];
    assign src_reg = ctrl.bright_sel;
    assign num = src_reg ? {6'h00, regs_reg[SLOT_BHI][1:0], regs_reg[SLOT_BLO]} : high_lat_reg;
    assign den = src_reg ? BRIGHT_FULL : period_lat_reg;
    assign duty_below = {num, 4'h0} < 20'(den) * 20'(DUTY_SIXTEENTHS[ctrl.change_duty]);
    assign fixed_on = 27'(rate_cnt_reg) * 27'(den) < 27'(num) * 27'(RATE_CYC);
    assign chopped = (src_reg || ctrl.fixed_rate) ? fixed_on : dim_s;
    assign pwm_on = src_reg ? fixed_on : dim_s;
    assign mode_now = !ctrl.mode ? DIM_PWM : (ctrl.change_duty == DUTY_ZERO ? DIM_DC : DIM_MIXED);

    // above threshold the duty-to-amplitude scaling sits in the analog stage
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            DIM_CTRL <= dim_ctrl_t'(SLOT_RST[SLOT_DIM]);
            DIM_MODE <= DIM_PWM;
            LED_SINK_ON <= 1'b0;
            LED_SINK_CURRENT <= 8'h00;
        end else begin
            DIM_CTRL <= ctrl;
            DIM_MODE <= mode_now;
            if (mode_now == DIM_PWM) begin
                LED_SINK_ON <= pwm_on;
                LED_SINK_CURRENT <= cur_byte;
            end else if (duty_below) begin
                LED_SINK_ON <= chopped;
                LED_SINK_CURRENT <= {2'b00, cur_byte[7:2]};
            end else begin
                LED_SINK_ON <= 1'b1;
                LED_SINK_CURRENT <= cur_byte;
            end
        end
    end

    sequence addr_byte_s;
        state_reg == I_ADDR && scl_fall && bit_cnt_reg == BYTE_BITS && !stop;
    endsequence

    mode_pwm_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !ctrl.mode |=> DIM_MODE == DIM_PWM) else $error("pwm mode not decoded");
    dc_mode_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ctrl.mode && ctrl.change_duty == DUTY_ZERO |=> DIM_MODE == DIM_DC)
        else $error("dc mode not decoded");
    mixed_mode_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ctrl.mode && ctrl.change_duty != DUTY_ZERO |=> DIM_MODE == DIM_MIXED)
        else $error("mixed mode not decoded");
    addr_ack_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        addr_byte_s ##0 shift_reg[7:1] == TARGET_ADDR |=> !SDA_OE_N && state_reg == I_ACK)
        else $error("own address not acknowledged");
    addr_nack_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        addr_byte_s ##0 shift_reg[7:1] != TARGET_ADDR |=> SDA_OE_N && state_reg == I_IDLE)
        else $error("foreign address answered");
    pwm_follow_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        mode_now == DIM_PWM && !src_reg |=> LED_SINK_ON == $past(dim_s))
        else $error("sink not following pin");
    quarter_amp_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        mode_now == DIM_MIXED && duty_below |=> LED_SINK_CURRENT == ($past(cur_byte) >> 2))
        else $error("low duty amplitude not quarter");
    rate_wrap_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        rate_cnt_reg == RATE_LAST |=> rate_cnt_reg == 10'h000)
        else $error("fixed rate period wrong");
    load_start_a: assert property (@(posedge SYS_CLK)
        $fell(RESET) |-> otp_state_reg == OTP_LOAD && ld_cnt_reg == 3'h0
            && regs_reg[SLOT_DIM] == SLOT_RST[SLOT_DIM])
        else $error("reset defaults not loaded");
    otp_load_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ld_en && ld_idx == slot_t'(SLOT_CUR) |=> regs_reg[SLOT_CUR] == $past(otp_rdata))
        else $error("burnt value not loaded");
endmodule : led_dimming_config_regs

// ==== test/i2c_host_model.sv ====
/*
 * Behavioural I2C bus controller standing in for the host processor.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/100ps
module i2c_host_model import led_cfg_pkg::*; (
    // clock
    input wire logic clk,
    // bus
    input wire logic sda_wire,
    output logic scl,
    output logic sda_rel
);
    // 4 x 13 cycles = 2.6 us a bit, under the 400 kb/s ceiling
    localparam int QUARTER = 13;

    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic wait_q(input int n);
        repeat (n * QUARTER) @(posedge clk);
        #1;
    endtask : wait_q

    // also serves as repeated start: data rises while clock is low
    task automatic start_cond();
        sda_rel = 1'b1;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        sda_rel = 1'b0;
        wait_q(1);
        scl = 1'b0;
        wait_q(1);
    endtask : start_cond

    task automatic stop_cond();
        sda_rel = 1'b0;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        sda_rel = 1'b1;
        wait_q(2);
    endtask : stop_cond

    // data changes only while clock is low, sampled mid-high
    task automatic clock_bit(input logic b, output logic got);
        sda_rel = b;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        got = sda_wire;
        wait_q(1);
        scl = 1'b0;
        wait_q(1);
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic g;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], g);
        clock_bit(1'b1, g);
        acked = ~g;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
        clock_bit(~ack, g);
    endtask : recv_byte

    // touches only the place the caller names
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] val, output logic acked);
        logic a;
        start_cond();
        send_byte({dev, 1'b0}, acked);
        if (acked) begin
            send_byte(ptr, a);
            send_byte(val, a);
        end
        stop_cond();
    endtask : write_reg

    // last byte is refused with a nack so the target lets go of the wire
    task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] q [$]);
        logic a;
        logic [7:0] b;
        q = {};
        start_cond();
        send_byte({TARGET_ADDR, 1'b0}, a);
        send_byte(ptr, a);
        start_cond();
        send_byte({TARGET_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            recv_byte(i < n - 1, b);
            q.push_back(b);
        end
        stop_cond();
    endtask : read_regs
endmodule : i2c_host_model

// ==== test/led_dimming_config_regs_bench.sv ====
/*
 * Self-checking bench of the dimming register bank, driven over I2C.
 * Assumes the host model on the bus and a pull-up on the data wire.
 */
`timescale 1ns/100ps
module led_dimming_config_regs_bench import led_cfg_pkg::*; ;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic fuse_clear = 1'b1;
    logic dim_in = 1'b0;
    logic scl, sda_rel, sda_out, sda_oe_n, sink_on, otp_busy, ack;
    logic [7:0] sink_cur;
    logic [7:0] q [$];
    dim_ctrl_t dim_ctrl;
    dim_mode_t dim_mode;
    int failures = 0;
    int n_checks = 0;
    int n;
    wire sda_wire = sda_rel & (sda_oe_n | sda_out);
    localparam logic [7:0] MODE_VAL [7] = '{8'h4D, 8'h41, 8'h45, 8'h49, 8'hCD, 8'h4C, 8'h40};
    localparam dim_mode_t MODE_EXP [7] = '{DIM_MIXED, DIM_DC, DIM_MIXED, DIM_MIXED,
                                          DIM_MIXED, DIM_PWM, DIM_PWM};

    always #25 sys_clk = ~sys_clk;

    led_dimming_config_regs dut (.SYS_CLK(sys_clk), .RESET(reset), .FUSE_CLEAR(fuse_clear),
        .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .DIM_IN(dim_in), .DIM_CTRL(dim_ctrl), .DIM_MODE(dim_mode), .LED_SINK_ON(sink_on),
        .LED_SINK_CURRENT(sink_cur), .OTP_BUSY(otp_busy));
    i2c_host_model host (.clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));

    task automatic cycles(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cycles

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
        host.write_reg(TARGET_ADDR, ptr, val, ack);
        chk({7'h00, ack}, 8'h01, "address ack");
    endtask : wr

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp [$], input string what);
        host.read_regs(ptr, exp.size(), q);
        foreach (exp[i]) chk(q[i], exp[i], what);
    endtask : rd_chk

    // bounded wait for the storage load or burn to finish
    task automatic settle();
        int k = 0;
        while (otp_busy !== 1'b0 && k < 50) begin
            cycles(1);
            k++;
        end
        chk({7'h00, otp_busy}, 8'h00, "storage idle");
    endtask : settle

    task automatic pulses(input int high, input int period, input int count);
        repeat (count) begin
            dim_in = 1'b1;
            cycles(high);
            dim_in = 1'b0;
            cycles(period - high);
        end
    endtask : pulses

    task automatic count_rises(input int span, output int c);
        logic prev;
        c = 0;
        prev = sink_on;
        repeat (span) begin
            cycles(1);
            if (sink_on === 1'b1 && prev === 1'b0) c++;
            prev = sink_on;
        end
    endtask : count_rises

    task automatic sink_is(input logic on, input logic [7:0] cur, input string what);
        chk({7'h00, sink_on}, {7'h00, on}, what);
        chk(sink_cur, cur, what);
    endtask : sink_is

    initial begin
        cycles(8);
        reset = 1'b0;
        fuse_clear = 1'b0;
        settle();
        chk(dim_ctrl, 8'h4C, "control after reset");
        rd_chk(8'h00, '{8'h4C, 8'h76, 8'h92, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                        8'h1C, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, "reset value");
        host.write_reg(7'h30, 8'h00, 8'h41, ack);
        chk({7'h00, ack}, 8'h00, "foreign address");
        wr(8'h51, 8'h5A);
        rd_chk(8'h50, '{8'h06, 8'h00}, "restricted");
        chk(dim_ctrl, 8'h4C, "control untouched");
        foreach (MODE_VAL[i]) begin
            wr(8'h00, MODE_VAL[i]);
            chk(dim_ctrl, MODE_VAL[i], "control copy");
            chk({6'h00, dim_mode}, {6'h00, MODE_EXP[i]}, "decoded mode");
        end
        rd_chk(8'h00, '{8'h40}, "control readback");
        wr(8'h02, 8'hA4);
        wr(8'h00, 8'h4C);
        pulses(6, 12, 1);
        dim_in = 1'b1;
        cycles(6);
        sink_is(1'b1, 8'hA4, "pwm on");
        dim_in = 1'b0;
        cycles(6);
        sink_is(1'b0, 8'hA4, "pwm off");
        wr(8'h00, 8'h4D);
        pulses(20, 200, 3);
        dim_in = 1'b1;
        cycles(6);
        sink_is(1'b1, 8'h29, "quarter on");
        dim_in = 1'b0;
        cycles(6);
        sink_is(1'b0, 8'h29, "quarter off");
        wr(8'h00, 8'hCD);
        // two pin periods first, so the latched duty no longer moves
        fork
            pulses(20, 200, 12);
            begin
                cycles(400);
                count_rises(3 * int'(RATE_CYC), n);
            end
        join
        chk(8'(n), 8'h03, "fixed rate rises");
        wr(8'h00, 8'h4D);
        pulses(50, 200, 3);
        dim_in = 1'b1;
        cycles(6);
        dim_in = 1'b0;
        cycles(20);
        sink_is(1'b1, 8'hA4, "at threshold");
        wr(8'h00, 8'h4F);
        wr(8'h04, 8'hFF);
        count_rises(int'(RATE_CYC), n);
        chk(8'(n), 8'h01, "register chop");
        chk(sink_cur, 8'h29, "register below");
        wr(8'h05, 8'h01);
        sink_is(1'b1, 8'hA4, "register above");
        wr(8'h02, 8'h55);
        wr(8'h00, 8'h49);
        wr(8'h60, 8'h01);
        settle();
        rd_chk(8'h60, '{8'h00}, "burn start clears");
        reset = 1'b1;
        cycles(8);
        reset = 1'b0;
        settle();
        rd_chk(8'h00, '{8'h49, 8'h76, 8'h55, 8'h00, 8'h00}, "burnt settings");
        chk({6'h00, dim_mode}, {6'h00, DIM_MIXED}, "burnt mode");
        summarize();
    end

    initial begin
        cycles(90000);
        failures++;
        summarize();
    end
endmodule : led_dimming_config_regs_bench
